/* File: cpu_ops_regs.svh */
// timing counts and bit positions for the rotate/subtract/skip execution unit
// assumes inclusion by bare name; definitions only
`ifndef CPU_OPS_REGS_SVH
`define CPU_OPS_REGS_SVH
`define DATA_W          8
`define MSB_POS         7
`define LSB_POS         0
`define NIBBLE_MSB      3
`define BYTE_ALL_ONES   8'hFF
`define BYTE_ZERO       8'h00
`define BYTE_ONE        8'h01
`define ACC_RESET       8'h00
`define FLAGS_RESET     4'h0
`define SKIP_CYCLES     2
`endif

/* File: cpu_ops_pkg.sv */
// types shared by the execution unit and its helpers
// assumes cpu_ops_regs.svh is on the include path
package cpu_ops_pkg;
  typedef enum logic [3:0] {
    op_nop,
    rotate_right_to_acc,
    rotate_right_carry_memory,
    rotate_right_carry_to_acc,
    borrow_subtract_to_acc,
    borrow_subtract_to_memory,
    plain_subtract_to_acc,
    decrement_skip_zero,
    decrement_skip_zero_to_acc,
    increment_skip_zero,
    increment_skip_zero_to_acc,
    set_byte,
    set_bit,
    bit_skip_nonzero
  } op_t;
  typedef enum logic {
    st_exec,
    st_dummy
  } phase_t;
endpackage

/* File: sub_unit.sv */
// eight-bit subtractor with borrow input and status flag generation
// purely combinational; caller registers the results
`timescale 1ns/100ps
`default_nettype none
`include "cpu_ops_regs.svh"
module sub_unit #(
  parameter int W = `DATA_W
) (
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  input  wire logic         no_borrow_in,
  output logic [W-1:0]      diff,
  output logic              carry_out,
  output logic              aux_out,
  output logic              ovf_out,
  output logic              zero_out
);
  wire logic [W:0] wide_diff;
  wire logic [4:0] low_diff;
  // adding the inverted operand gives carry set means no borrow
  assign wide_diff = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, no_borrow_in};
  assign low_diff  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, no_borrow_in};
  assign diff      = wide_diff[W-1:0];
  assign carry_out = wide_diff[W];
  assign aux_out   = low_diff[4];
  assign ovf_out   = (minuend[W-1] != subtrahend[W-1]) && (diff[W-1] != minuend[W-1]);
  assign zero_out  = (diff == {W{1'b0}});
endmodule
`default_nettype wire

/* File: bit_select.sv */
// single-bit set mask and test for a byte
// combinational; bit index is taken as given
`timescale 1ns/100ps
`default_nettype none
module bit_select #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]         data_in,
  input  wire logic [$clog2(W)-1:0] bit_idx,
  output logic [W-1:0]              set_out,
  output logic                      bit_val
);
  localparam int IW = $clog2(W);
  wire logic [W-1:0] mask;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_mask
      // cast rather than part-select: a genvar has no bits to slice
      assign mask[g] = (bit_idx == IW'(g));
    end
  endgenerate
  assign set_out = data_in | mask;
  assign bit_val = |(data_in & mask);
endmodule
`default_nettype wire

/* File: cpu_rotate_sub_skip_ops.sv */
// execution unit for rotates, subtracts, skip-on-count and bit set/test
// assumes memory byte is read combinationally and written back from mem_wdata on mem_we
`timescale 1ns/100ps
`default_nettype none
`include "cpu_ops_regs.svh"
module cpu_rotate_sub_skip_ops #(
  parameter int W = `DATA_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  op_valid,
  input  wire cpu_ops_pkg::op_t      op_code,
  input  wire logic [W-1:0]          mem_rdata,
  input  wire logic [$clog2(W)-1:0]  bit_idx,
  output logic                       op_ready,
  output logic [W-1:0]               acc_out,
  output logic                       flag_c,
  output logic                       flag_z,
  output logic                       flag_ac,
  output logic                       flag_ov,
  output logic                       mem_we,
  output logic [W-1:0]               mem_wdata,
  output logic                       skip_next,
  output logic                       dummy_cycle
);
  import cpu_ops_pkg::*;

  phase_t      phase_reg;
  phase_t      phase_next;
  logic [W-1:0] acc_reg;
  logic [W-1:0] acc_next;
  logic        c_reg;
  logic        c_next;
  logic        z_reg;
  logic        z_next;
  logic        ac_reg;
  logic        ac_next;
  logic        ov_reg;
  logic        ov_next;
  logic        we_reg;
  logic        we_next;
  logic [W-1:0] wdata_reg;
  logic [W-1:0] wdata_next;
  logic        skip_reg;
  logic        skip_next_w;

  wire logic [W-1:0] s_diff;
  wire logic         s_c;
  wire logic         s_ac;
  wire logic         s_ov;
  wire logic         s_z;
  wire logic [W-1:0] bit_set_val;
  wire logic         bit_is_set;
  wire logic         take;
  wire logic         is_sub;
  wire logic         is_borrow;
  wire logic [W-1:0] rot_plain;
  wire logic [W-1:0] rot_carry;
  wire logic [W-1:0] dec_val;
  wire logic [W-1:0] inc_val;

  sub_unit #(.W(W)) u_sub (
    .minuend      (acc_reg),
    .subtrahend   (mem_rdata),
    .no_borrow_in (is_borrow ? c_reg : 1'b1),
    .diff         (s_diff),
    .carry_out    (s_c),
    .aux_out      (s_ac),
    .ovf_out      (s_ov),
    .zero_out     (s_z)
  );

  bit_select #(.W(W)) u_bit (
    .data_in (mem_rdata),
    .bit_idx (bit_idx),
    .set_out (bit_set_val),
    .bit_val (bit_is_set)
  );

  // new op accepted only in the execute phase; dummy cycle stalls the issuer
  assign take      = op_valid && (phase_reg == st_exec);
  assign is_borrow = (op_code == borrow_subtract_to_acc) || (op_code == borrow_subtract_to_memory);
  assign is_sub    = is_borrow || (op_code == plain_subtract_to_acc);
  assign rot_plain = {mem_rdata[`LSB_POS], mem_rdata[W-1:1]};
  assign rot_carry = {c_reg, mem_rdata[W-1:1]};
  assign dec_val   = mem_rdata - `BYTE_ONE;
  assign inc_val   = mem_rdata + `BYTE_ONE;

  always_comb begin
    acc_next    = acc_reg;
    c_next      = c_reg;
    z_next      = z_reg;
    ac_next     = ac_reg;
    ov_next     = ov_reg;
    we_next     = 1'b0;
    wdata_next  = wdata_reg;
    skip_next_w = 1'b0;
    phase_next  = st_exec;
    if (take) begin
      unique case (op_code)
        rotate_right_to_acc: begin
          acc_next = rot_plain;
        end
        rotate_right_carry_memory: begin
          we_next    = 1'b1;
          wdata_next = rot_carry;
          c_next     = mem_rdata[`LSB_POS];
        end
        rotate_right_carry_to_acc: begin
          acc_next = rot_carry;
          c_next   = mem_rdata[`LSB_POS];
        end
        borrow_subtract_to_acc, plain_subtract_to_acc: begin
          acc_next = s_diff;
        end
        borrow_subtract_to_memory: begin
          we_next    = 1'b1;
          wdata_next = s_diff;
        end
        decrement_skip_zero: begin
          we_next     = 1'b1;
          wdata_next  = dec_val;
          skip_next_w = (dec_val == `BYTE_ZERO);
        end
        decrement_skip_zero_to_acc: begin
          acc_next    = dec_val;
          skip_next_w = (dec_val == `BYTE_ZERO);
        end
        increment_skip_zero: begin
          we_next     = 1'b1;
          wdata_next  = inc_val;
          skip_next_w = (inc_val == `BYTE_ZERO);
        end
        increment_skip_zero_to_acc: begin
          acc_next    = inc_val;
          skip_next_w = (inc_val == `BYTE_ZERO);
        end
        set_byte: begin
          we_next    = 1'b1;
          wdata_next = `BYTE_ALL_ONES;
        end
        set_bit: begin
          we_next    = 1'b1;
          wdata_next = bit_set_val;
        end
        bit_skip_nonzero: begin
          skip_next_w = bit_is_set;
        end
        default: begin
        end
      endcase
      if (is_sub) begin
        c_next  = s_c;
        z_next  = s_z;
        ac_next = s_ac;
        ov_next = s_ov;
      end
      if (skip_next_w) begin
        phase_next = st_dummy;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= st_exec;
      acc_reg   <= `ACC_RESET;
      {c_reg, z_reg, ac_reg, ov_reg} <= `FLAGS_RESET;
      we_reg    <= 1'b0;
      wdata_reg <= `BYTE_ZERO;
      skip_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      acc_reg   <= acc_next;
      {c_reg, z_reg, ac_reg, ov_reg} <= {c_next, z_next, ac_next, ov_next};
      we_reg    <= we_next;
      wdata_reg <= wdata_next;
      skip_reg  <= skip_next_w;
    end
  end

  // outputs straight from flip-flops; ready low during the inserted dummy cycle
  assign op_ready    = (phase_reg == st_exec);
  assign dummy_cycle = (phase_reg == st_dummy);
  assign acc_out     = acc_reg;
  assign flag_c      = c_reg;
  assign flag_z      = z_reg;
  assign flag_ac     = ac_reg;
  assign flag_ov     = ov_reg;
  assign mem_we      = we_reg;
  assign mem_wdata   = wdata_reg;
  assign skip_next   = skip_reg;
endmodule
`default_nettype wire

/* File: cpu_ops_checker.sv */
// assertions on the ports of the rotate/subtract/skip unit
// assumes a bind into the top module; one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module cpu_ops_checker #(
  parameter int W = 8
) (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 op_valid,
  input wire cpu_ops_pkg::op_t     op_code,
  input wire logic [W-1:0]         mem_rdata,
  input wire logic [$clog2(W)-1:0] bit_idx,
  input wire logic                 op_ready,
  input wire logic [W-1:0]         acc_out,
  input wire logic                 flag_c,
  input wire logic                 mem_we,
  input wire logic [W-1:0]         mem_wdata,
  input wire logic                 skip_next,
  input wire logic                 dummy_cycle
);
  import cpu_ops_pkg::*;
  logic [W-1:0]         m_reg;
  logic [$clog2(W)-1:0] b_reg;
  wire logic            tk = op_valid && op_ready;
  // operands sampled every cycle, so results of a taken op can be tied to their cause
  always_ff @(posedge core_clk) begin
    m_reg <= mem_rdata;
    b_reg <= bit_idx;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_skip_dummy_pair: assert property (dummy_cycle == skip_next && op_ready == !dummy_cycle)
    else $error("skip and dummy out of step");
  chk_dummy_one_cycle: assert property (!op_ready |=> op_ready)
    else $error("dummy longer than one cycle");
  chk_refused_idle: assert property (!op_ready && op_valid |=> !mem_we && !skip_next)
    else $error("op taken during dummy");
  chk_rotate_acc: assert property (tk && op_code == rotate_right_to_acc
    |=> acc_out == {m_reg[0], m_reg[W-1:1]} && $stable(flag_c) && !mem_we) else $error("rotate to acc wrong");
  chk_rrc_mem: assert property (tk && op_code == rotate_right_carry_memory
    |=> mem_we && mem_wdata == {$past(flag_c), m_reg[W-1:1]} && flag_c == m_reg[0]) else $error("rrc mem wrong");
  chk_rrc_acc: assert property (tk && op_code == rotate_right_carry_to_acc
    |=> acc_out == {$past(flag_c), m_reg[W-1:1]} && flag_c == m_reg[0] && !mem_we) else $error("rrc acc wrong");
  chk_dec_skip: assert property (tk && op_code == decrement_skip_zero
    |=> mem_we && mem_wdata == W'(m_reg - 1) && skip_next == (m_reg == 1) && $stable(flag_c)) else $error("dec skip wrong");
  chk_inc_acc: assert property (tk && op_code == increment_skip_zero_to_acc
    |=> acc_out == W'(m_reg + 1) && !mem_we && skip_next == (m_reg == {W{1'b1}})) else $error("inc acc wrong");
  chk_set_byte: assert property (tk && op_code == set_byte |=> mem_we && mem_wdata == {W{1'b1}})
    else $error("set byte wrong");
  chk_set_bit: assert property (tk && op_code == set_bit |=> mem_we && mem_wdata == (m_reg | (W'(1) << b_reg)))
    else $error("set bit wrong");
  chk_bit_skip: assert property (tk && op_code == bit_skip_nonzero |=> skip_next == m_reg[b_reg] && !mem_we)
    else $error("bit skip wrong");
endmodule
bind cpu_rotate_sub_skip_ops cpu_ops_checker #(.W(W)) cpu_ops_checker_inst (.core_clk, .rst_n, .op_valid, .op_code,
  .mem_rdata, .bit_idx, .op_ready, .acc_out, .flag_c, .mem_we, .mem_wdata, .skip_next, .dummy_cycle);
`default_nettype wire

/* File: cpu_rotate_sub_skip_ops_tb_top.sv */
// testbench for the rotate/subtract/skip unit: reference model with queued expectations
// assumes package, header and design compiled first
`timescale 1ns/100ps
`default_nettype none
module cpu_rotate_sub_skip_ops_tb_top;
  import cpu_ops_pkg::*;
  logic        core_clk  = 0;
  logic        rst_n     = 0;
  logic        op_valid  = 0;
  op_t         op_code   = op_nop;
  logic [7:0]  mem_rdata = 8'h00;
  logic [2:0]  bit_idx   = 3'h0;
  logic        op_ready, flag_c, flag_z, flag_ac, flag_ov, mem_we, skip_next, dummy_cycle;
  logic [7:0]  acc_out, mem_wdata;
  logic [23:0] exp_q[$];
  logic        taken_reg = 0;
  int          failures  = 0;
  int          cmp_count = 0;
  logic [31:0] seed      = 32'h52;
  logic [7:0]  a_m       = 8'h00;
  logic        c_m = 0, z_m = 0, ac_m = 0, ov_m = 0;
  always #4 core_clk = ~core_clk;
  cpu_rotate_sub_skip_ops cpu_rotate_sub_skip_ops_inst (.core_clk, .rst_n, .op_valid, .op_code, .mem_rdata,
    .bit_idx, .op_ready, .acc_out, .flag_c, .flag_z, .flag_ac, .flag_ov, .mem_we, .mem_wdata, .skip_next,
    .dummy_cycle);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // model updates at presentation; every op passed to run_op is taken since we wait out the dummy
  task run_op(input op_t o, input logic [7:0] m, input logic [2:0] b);
    logic [8:0] d;
    logic [4:0] n;
    logic [7:0] w;
    logic       we, s, ci;
    w = 8'h00; we = 0; s = 0;
    ci = (o == plain_subtract_to_acc) ? 1'b1 : c_m;
    d = {1'b0, a_m} + {1'b0, ~m} + 9'(ci);
    n = {1'b0, a_m[3:0]} + {1'b0, ~m[3:0]} + 5'(ci);
    case (o)
      rotate_right_to_acc: a_m = {m[0], m[7:1]};
      rotate_right_carry_memory: begin w = {c_m, m[7:1]}; we = 1; c_m = m[0]; end
      rotate_right_carry_to_acc: begin a_m = {c_m, m[7:1]}; c_m = m[0]; end
      borrow_subtract_to_acc, plain_subtract_to_acc, borrow_subtract_to_memory: begin
        ov_m = (a_m[7] != m[7]) && (d[7] != a_m[7]);
        c_m = d[8]; z_m = (d[7:0] == 8'h00); ac_m = n[4];
        if (o == borrow_subtract_to_memory) begin w = d[7:0]; we = 1; end
        else a_m = d[7:0];
      end
      decrement_skip_zero: begin w = m - 8'h01; we = 1; s = (w == 8'h00); end
      decrement_skip_zero_to_acc: begin a_m = m - 8'h01; s = (a_m == 8'h00); end
      increment_skip_zero: begin w = m + 8'h01; we = 1; s = (w == 8'h00); end
      increment_skip_zero_to_acc: begin a_m = m + 8'h01; s = (a_m == 8'h00); end
      set_byte: begin w = 8'hFF; we = 1; end
      set_bit: begin w = m | (8'h01 << b); we = 1; end
      bit_skip_nonzero: s = m[b];
      default: ;
    endcase
    exp_q.push_back({a_m, c_m, z_m, ac_m, ov_m, we, w, s, s, s});
    op_valid <= 1; op_code <= o; mem_rdata <= m; bit_idx <= b;
    @(posedge core_clk);
    // a request held up during the dummy cycle must be ignored
    if (s) begin op_code <= set_byte; mem_rdata <= ~m; @(posedge core_clk); end
  endtask
  always @(posedge core_clk) taken_reg <= op_valid && op_ready && rst_n;
  always @(negedge core_clk) if (taken_reg) chk("outputs", {acc_out, flag_c, flag_z, flag_ac, flag_ov, mem_we,
    mem_we ? mem_wdata : 8'h00, skip_next, dummy_cycle, ~op_ready}, exp_q.pop_front());
  initial begin
    repeat (2000) @(posedge core_clk);
    failures++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1;
    chk("reset", {8'h00, acc_out, flag_c, flag_z, flag_ac, flag_ov, mem_we, skip_next, dummy_cycle, op_ready},
      {8'h00, 8'h00, 4'h0, 3'h0, 1'b1});
    @(posedge core_clk);
    // biased operands hit the wrap values that make count skips fire
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      run_op(op_t'(4'(seed[3:0] % 4'hE)), seed[8] ? ({7'h00, seed[9]} ^ {8{seed[10]}}) : seed[23:16], seed[13:11]);
    end
    op_valid <= 0;
    repeat (3) @(posedge core_clk);
    end_sim;
  end
endmodule
`default_nettype wire
